// *** logic/eeprom_port_pkg.sv ***
// Constants for the data EEPROM access port
package eeprom_port_pkg;
   // I/O register offsets (the exact I/O locations are chosen here)
   localparam logic [5:0] ADDR_HIGH_OFS = 6'h1F;
   localparam logic [5:0] ADDR_LOW_OFS  = 6'h1E;
   localparam logic [5:0] DATA_OFS      = 6'h1D;
   localparam logic [5:0] CONTROL_OFS   = 6'h1C;
   // Array geometry
   localparam int         ADDR_W        = 9;
   localparam int         DEPTH         = 512;
   // Control register fields
   localparam int         BIT_MODE_HI   = 5;
   localparam int         BIT_MODE_LO   = 4;
   localparam int         BIT_RIE       = 3;
   localparam int         BIT_MPE       = 2;
   localparam int         BIT_PE        = 1;
   localparam int         BIT_RE        = 0;
   localparam logic [1:0] MODE_ATOMIC   = 2'h0;
   localparam logic [1:0] MODE_ERASE    = 2'h1;
   localparam logic [1:0] MODE_WRITE    = 2'h2;
   localparam logic [1:0] MODE_RSVD     = 2'h3;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;
   // Timing
   localparam int         CLK_HZ        = 40_000_000;
   localparam int         T_ATOMIC_US   = 3400;
   localparam int         T_SPLIT_US    = 1800;
   localparam int         ATOMIC_CYC    = T_ATOMIC_US * (CLK_HZ / 1_000_000);
   localparam int         SPLIT_CYC     = T_SPLIT_US * (CLK_HZ / 1_000_000);
   localparam int         MPE_CYC       = 4;
   localparam int         READ_STALL    = 4;
   localparam int         WRITE_STALL   = 2;
   localparam int         CNT_W         = 18;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_PROG  = 2'b01
   } prog_state_t;
endpackage

// *** logic/eeprom_data_access_port.sv ***
// Data EEPROM array with its CPU I/O register port
`timescale 1ns/1ps
// Operation
// - Separate 512-byte array, single bytes read and written.
// - Address, data and control registers sit in I/O space.
// - A read strobe stalls the CPU for four cycles.
// - Starting a write stalls the CPU for two cycles.
// - Program enable bit stays readable as a busy flag.
// - Program enable only starts when master enable is still set.
// - High address bit 0 is the ninth address bit.
// - High address bits 7..1 read zero.
// - Combined address picks byte 0 to 511 linearly.
// - Data register supplies the byte being written.
// - Read places the addressed byte into the data register.
// - Control bits 7 and 6 read zero.
// - Mode field selects atomic, erase or write; locked while busy.
// - Master enable clears itself after four cycles.
// - Program enable clears at end; reads and address writes blocked.
// - Ready interrupt held while enabled, global enable set, idle.
module eeprom_data_access_port
   import eeprom_port_pkg::*;
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   // CPU I/O access
   input  wire logic [5:0] i_io_addr,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_wdata,
   output logic      [7:0] o_io_rdata,
   // CPU control
   input  wire logic       i_global_irq_en,
   output logic            o_cpu_stall,
   output logic            o_ready_irq
);

   // Storage array, one byte per address
   logic [7:0]        mem [DEPTH];
   // Programming registers and their counters
   logic              addr_hi;
   logic [7:0]        addr_lo;
   logic [7:0]        data_byte;
   logic [1:0]        mode;
   logic              rie;
   logic              mpe;
   logic              pe;
   logic [2:0]        mpe_cnt;
   logic [2:0]        stall_cnt;
   logic [CNT_W-1:0]  prog_cnt;
   prog_state_t       state;
   // Next values, one set per register group
   logic              next_addr_hi;
   logic [7:0]        next_addr_lo;
   logic [7:0]        next_data_byte;
   logic [1:0]        next_mode;
   logic              next_rie;
   logic              next_mpe;
   logic              next_pe;
   logic [2:0]        next_mpe_cnt;
   logic [2:0]        next_stall_cnt;
   logic [CNT_W-1:0]  next_prog_cnt;
   prog_state_t       next_state;
   logic [7:0]        next_io_rdata;
   logic [7:0]        next_cell;

   // Decoded strobes and combined address
   logic [ADDR_W-1:0] addr;
   logic              wr_hi;
   logic              wr_lo;
   logic              wr_data;
   logic              wr_ctl;
   logic              start;
   logic              read_go;
   logic              prog_done;
   logic [7:0]        control_rd;

   // Nine-bit linear address
   assign addr    = {addr_hi, addr_lo};

   // Register decode on the I/O offset
   assign wr_hi   = i_io_wr && (i_io_addr == ADDR_HIGH_OFS);
   assign wr_lo   = i_io_wr && (i_io_addr == ADDR_LOW_OFS);
   assign wr_data = i_io_wr && (i_io_addr == DATA_OFS);
   assign wr_ctl  = i_io_wr && (i_io_addr == CONTROL_OFS);
   // Program enable accepted only within the master enable window
   assign start   = wr_ctl && i_io_wdata[BIT_PE] && mpe && !pe
                    && (mode != MODE_RSVD);
   // No read while a programming cycle owns the array
   assign read_go = wr_ctl && i_io_wdata[BIT_RE] && !pe && !start;
   assign prog_done = (state == ST_PROG) && (prog_cnt == '0);
   // Reserved bits 7,6 read zero; read strobe never reads back set
   assign control_rd = {2'b00, mode, rie, mpe, pe, 1'b0};

   // Address group: writes blocked while a programming cycle owns the array; reset still clears it
   always_comb begin
      next_addr_hi = addr_hi;
      next_addr_lo = addr_lo;
      if (wr_hi && !pe) begin
         next_addr_hi = i_io_wdata[0];
      end
      if (wr_lo && !pe) begin
         next_addr_lo = i_io_wdata;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         addr_hi <= 1'b0;
         addr_lo <= 8'h00;
      end else begin
         addr_hi <= next_addr_hi;
         addr_lo <= next_addr_lo;
      end
   end

   // Data group: a read strobe wins over a plain register load
   // Limitation: data stays writable while busy; the cycle uses it at end
   always_comb begin
      next_data_byte = data_byte;
      if (wr_data) begin
         next_data_byte = i_io_wdata;
      end
      if (read_go) begin
         next_data_byte = mem[addr];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         data_byte <= 8'h00;
      end else begin
         data_byte <= next_data_byte;
      end
   end

   // Control group: mode, ready enable and the master enable window
   always_comb begin
      next_mode    = mode;
      next_rie     = rie;
      next_mpe     = mpe;
      next_mpe_cnt = mpe_cnt;
      // Window counts down, then hardware clears it
      if (mpe) begin
         if (mpe_cnt == 3'h1) begin
            next_mpe = 1'b0;
         end
         next_mpe_cnt = mpe_cnt - 3'h1;
      end
      if (wr_ctl) begin
         next_rie = i_io_wdata[BIT_RIE];
         // The starting write keeps the mode that timed its cycle
         if (!pe && !start) begin
            next_mode = i_io_wdata[BIT_MODE_HI:BIT_MODE_LO];
         end
         if (i_io_wdata[BIT_MPE] && !mpe) begin
            next_mpe     = 1'b1;
            next_mpe_cnt = 3'(MPE_CYC);
         end
      end
      // One window buys one start only
      if (start) begin
         next_mpe     = 1'b0;
         next_mpe_cnt = 3'h0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rie     <= 1'b0;
         mpe     <= 1'b0;
         mpe_cnt <= 3'h0;
         // Reset does not abort programming, so the mode rides through
         if (state != ST_PROG) begin
            mode <= MODE_ATOMIC;
         end else begin
            mode <= next_mode;
         end
      end else begin
         mode    <= next_mode;
         rie     <= next_rie;
         mpe     <= next_mpe;
         mpe_cnt <= next_mpe_cnt;
      end
   end

   // Stall group: the strobe cycle is stalled combinationally, the
   // counter covers the cycles after it
   always_comb begin
      next_stall_cnt = stall_cnt;
      if (stall_cnt != 3'h0) begin
         next_stall_cnt = stall_cnt - 3'h1;
      end
      if (read_go) begin
         next_stall_cnt = 3'(READ_STALL);
      end
      if (start) begin
         next_stall_cnt = 3'(WRITE_STALL);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         stall_cnt <= 3'h0;
      end else begin
         stall_cnt <= next_stall_cnt;
      end
   end

   // Programming group: self-timed cycle that software polls
   always_comb begin
      next_pe       = pe;
      next_prog_cnt = prog_cnt;
      next_state    = state;
      unique case (state)
         ST_IDLE: begin
            if (start) begin
               next_pe    = 1'b1;
               next_state = ST_PROG;
               if (mode == MODE_ATOMIC) begin
                  next_prog_cnt = CNT_W'(ATOMIC_CYC - 1);
               end else begin
                  next_prog_cnt = CNT_W'(SPLIT_CYC - 1);
               end
            end
         end
         ST_PROG: begin
            if (prog_done) begin
               next_pe    = 1'b0;
               next_state = ST_IDLE;
            end else begin
               next_prog_cnt = prog_cnt - 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // A busy cycle keeps counting through reset
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n && state != ST_PROG) begin
         pe       <= 1'b0;
         prog_cnt <= '0;
         state    <= ST_IDLE;
      end else begin
         pe       <= next_pe;
         prog_cnt <= next_prog_cnt;
         state    <= next_state;
      end
   end

   // Array group: new cell value worked out from the mode
   always_comb begin
      next_cell = mem[addr];
      unique case (mode)
         MODE_ATOMIC: next_cell = data_byte;
         MODE_ERASE:  next_cell = ERASED_BYTE;
         MODE_WRITE:  next_cell = mem[addr] & data_byte;
         MODE_RSVD:   next_cell = mem[addr];
      endcase
   end

   // Array written once, at the end of the cycle; address held by lock, but a reset mid-cycle clears it to 0
   always_ff @(posedge i_sys_clk) begin
      if (prog_done) begin
         mem[addr] <= next_cell;
      end
   end

   // Read data holds until the next read strobe
   always_comb begin
      next_io_rdata = o_io_rdata;
      if (i_io_rd) begin
         unique case (i_io_addr)
            ADDR_HIGH_OFS: next_io_rdata = {7'h00, addr_hi};
            ADDR_LOW_OFS:  next_io_rdata = addr_lo;
            DATA_OFS:      next_io_rdata = data_byte;
            CONTROL_OFS:   next_io_rdata = control_rd;
            // Unmapped offsets read as zero
            default:       next_io_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_io_rdata <= 8'h00;
      end else begin
         o_io_rdata <= next_io_rdata;
      end
   end

   // Handshake outputs are combinational so the stall lands in time
   // Stall covers the strobe cycle plus the counted cycles
   assign o_cpu_stall = (stall_cnt != 3'h0) || read_go || start;
   assign o_ready_irq = rie && i_global_irq_en && !pe;

endmodule // eeprom_data_access_port

// *** tb/eeprom_data_access_port_properties.sv ***
// Port checker for the EEPROM access port
`timescale 1ns/1ps
module eeprom_data_access_port_properties
   import eeprom_port_pkg::*;
(
   input wire logic       i_sys_clk,
   input wire logic       i_rst_n,
   input wire logic [5:0] i_io_addr,
   input wire logic       i_io_wr,
   input wire logic       i_io_rd,
   input wire logic [7:0] i_io_wdata,
   input wire logic [7:0] o_io_rdata,
   input wire logic       i_global_irq_en,
   input wire logic       o_cpu_stall,
   input wire logic       o_ready_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   logic cw;
   assign cw = i_io_wr && i_io_addr == CONTROL_OFS;
   property p_rd_stall; $rose(o_cpu_stall) && cw && i_io_wdata[1:0] == 2'h1
      |=> o_cpu_stall[*4] ##1 !o_cpu_stall; endproperty
   a_rd_stall: assert property (p_rd_stall) else $error("rd stall");
   property p_wr_stall; $rose(o_cpu_stall) && cw && i_io_wdata[1:0] == 2'h2
      |=> o_cpu_stall[*2] ##1 !o_cpu_stall; endproperty
   a_wr_stall: assert property (p_wr_stall) else $error("wr stall");
   property p_stall_max; o_cpu_stall[*5] |=> !o_cpu_stall; endproperty
   a_stall_max: assert property (p_stall_max) else $error("long");
   property p_high; i_io_rd && i_io_addr == ADDR_HIGH_OFS
      |=> o_io_rdata[7:1] == 7'h00; endproperty
   a_high: assert property (p_high) else $error("high rsvd");
   property p_ctl; i_io_rd && cw == 1'b0 && i_io_addr == CONTROL_OFS
      |=> o_io_rdata[7:6] == 2'h0 && !o_io_rdata[0]; endproperty
   a_ctl: assert property (p_ctl) else $error("ctl rsvd");
   property p_hold; !$past(i_io_rd) |-> $stable(o_io_rdata); endproperty
   a_hold: assert property (p_hold) else $error("rdata moved");
   property p_gate; o_ready_irq |-> i_global_irq_en; endproperty
   a_gate: assert property (p_gate) else $error("irq gate");
   property p_busy; $rose(o_cpu_stall) && cw && i_io_wdata[1]
      |=> !o_ready_irq[*2]; endproperty
   a_busy: assert property (p_busy) else $error("irq busy");
   c_rd: cover property ($rose(o_cpu_stall) && i_io_wdata[0]);
   c_wr: cover property ($rose(o_cpu_stall) && i_io_wdata[1]);
   c_irq: cover property (o_ready_irq);
endmodule // eeprom_data_access_port_properties

// *** tb/cpu_io_model.sv ***
// CPU core model issuing I/O register accesses
`timescale 1ns/1ps
module cpu_io_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_stall,
   input  wire logic [7:0] i_rdata,
   output logic      [5:0] o_addr,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_wdata
);
   initial begin
      o_addr = 6'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   task automatic release_bus;
      o_wr = 1'b0;
      o_rd = 1'b0;
      // Released lines must not keep a stale value
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
      repeat (8) if (i_stall) @(negedge i_sys_clk);
   endtask
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      o_addr = a;
      o_wdata = {d[7] & (a != 6'h1C), d[6:0]};
      o_wr = 1'b1;
      @(negedge i_sys_clk);
      release_bus();
   endtask
   task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge i_sys_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_sys_clk);
      d = i_rdata;
      release_bus();
   endtask
endmodule // cpu_io_model

// *** tb/eeprom_data_access_port_tb.sv ***
// Self-checking bench for the EEPROM access port
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %0t: got %h want %h", $time, g, e); end end
module eeprom_data_access_port_tb;
   import eeprom_port_pkg::*;
   logic       i_sys_clk;
   logic       i_rst_n;
   logic       gie;
   logic       wr;
   logic       rd;
   logic       stall;
   logic       irq;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [7:0] r;
   integer     seed = 32'h36c6215a;
   int         failures = 0;
   int         cmp_count = 0;
   int         i;
   function automatic logic [7:0] high_view(input logic [7:0] w);
      return {7'h00, w[0]};
   endfunction
   eeprom_data_access_port dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
      .o_io_rdata(rdata), .i_global_irq_en(gie), .o_cpu_stall(stall),
      .o_ready_irq(irq));
   cpu_io_model cpu_u (.i_sys_clk(i_sys_clk), .i_stall(stall),
      .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   // Erase alone takes 72000 cycles
   initial begin
      repeat (90000) @(posedge i_sys_clk);
      failures++;
      finish_test();
   end
   initial begin
      i_rst_n = 1'b0;
      gie = 1'b1;
      repeat (8) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h00)
      cpu_u.io_rd(6'h05, r);
      `CHK(r, 8'h00)
      for (i = 0; i < 6; i++) begin
         v = $random(seed);
         gie = v[7];
         cpu_u.io_wr(ADDR_HIGH_OFS, v);
         cpu_u.io_rd(ADDR_HIGH_OFS, r);
         `CHK(r, high_view(v))
         cpu_u.io_wr(DATA_OFS, v);
         cpu_u.io_rd(DATA_OFS, r);
         `CHK(r, v)
         cpu_u.io_wr(CONTROL_OFS, {1'b0, v[6:3], 3'h0});
         cpu_u.io_rd(CONTROL_OFS, r);
         `CHK(r, {2'h0, v[5:3], 3'h0})
         `CHK(irq, v[3] & v[7])
      end
      gie = 1'b1;
      cpu_u.io_wr(ADDR_LOW_OFS, 8'hA5);
      cpu_u.io_wr(ADDR_HIGH_OFS, 8'h01);
      cpu_u.io_wr(CONTROL_OFS, 8'h1A);
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h18)
      cpu_u.io_wr(CONTROL_OFS, 8'h1C);
      repeat (6) @(negedge i_sys_clk);
      cpu_u.io_wr(CONTROL_OFS, 8'h1A);
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h18)
      cpu_u.io_wr(DATA_OFS, 8'h3C);
      cpu_u.io_wr(CONTROL_OFS, 8'h1C);
      cpu_u.io_wr(CONTROL_OFS, 8'h1A);
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h1A)
      `CHK(irq, 1'b0)
      cpu_u.io_wr(ADDR_LOW_OFS, 8'h00);
      cpu_u.io_wr(CONTROL_OFS, 8'h29);
      cpu_u.io_rd(ADDR_LOW_OFS, r);
      `CHK(r, 8'hA5)
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h1A)
      cpu_u.io_rd(DATA_OFS, r);
      `CHK(r, 8'h3C)
      // Reset mid-cycle: the programming cycle and its mode survive
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h12)
      cpu_u.io_wr(CONTROL_OFS, 8'h08);
      for (i = 0; i < 900 && r[1]; i++) begin
         repeat (100) @(negedge i_sys_clk);
         cpu_u.io_rd(CONTROL_OFS, r);
      end
      `CHK(r, 8'h18)
      `CHK(irq, 1'b1)
      cpu_u.io_wr(CONTROL_OFS, 8'h01);
      cpu_u.io_rd(DATA_OFS, r);
      `CHK(r, ERASED_BYTE)
      cpu_u.io_rd(CONTROL_OFS, r);
      `CHK(r, 8'h00)
      finish_test();
   end
endmodule // eeprom_data_access_port_tb
bind eeprom_data_access_port eeprom_data_access_port_properties chk_u (
   .i_sys_clk, .i_rst_n, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata,
   .o_io_rdata, .i_global_irq_en, .o_cpu_stall, .o_ready_irq);
